// File: hw/cesbd_pkg.sv
// shared constants and types for the can error state and bus diagnostics block
package cesbd_pkg;

    // register byte offsets
    localparam logic [11:0] CESBD_OFS_ERR_COUNT = 12'h000;
    localparam logic [11:0] CESBD_OFS_DIAG_CNT = 12'h004;
    localparam logic [11:0] CESBD_OFS_DIAG_FLAGS = 12'h008;
    localparam logic [11:0] CESBD_OFS_CTRL = 12'h00C;

    // error state thresholds
    localparam logic [8:0] CESBD_BUS_OFF_LIMIT = 9'h0FF;
    localparam logic [8:0] CESBD_PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] CESBD_WARN_LOW = 9'h05F;
    localparam logic [8:0] CESBD_WARN_HIGH = 9'h080;

    // status field positions in the error count register
    localparam int CESBD_POS_BUS_OFF = 21;
    localparam int CESBD_POS_TX_PASSIVE = 20;
    localparam int CESBD_POS_RX_PASSIVE = 19;
    localparam int CESBD_POS_TX_WARN = 18;
    localparam int CESBD_POS_RX_WARN = 17;
    localparam int CESBD_POS_ANY_WARN = 16;

    // diagnostic flag positions, upper half of the flags register
    localparam int CESBD_POS_DLC_MM = 31;
    localparam int CESBD_POS_ESI = 30;
    localparam int CESBD_POS_D_CRC = 29;
    localparam int CESBD_POS_D_STUFF = 28;
    localparam int CESBD_POS_D_FORM = 27;
    localparam int CESBD_POS_D_BIT1 = 25;
    localparam int CESBD_POS_D_BIT0 = 24;
    localparam int CESBD_POS_BO_EVT = 23;
    localparam int CESBD_POS_N_CRC = 21;
    localparam int CESBD_POS_N_STUFF = 20;
    localparam int CESBD_POS_N_FORM = 19;
    localparam int CESBD_POS_N_ACK = 18;
    localparam int CESBD_POS_N_BIT1 = 17;
    localparam int CESBD_POS_N_BIT0 = 16;

    // implemented flag bits (26 and 22 read zero)
    localparam logic [15:0] CESBD_FLAG_MASK = 16'hFBBF;

    // reset values
    localparam logic [7:0] CESBD_CNT_RESET = 8'h00;
    localparam logic [15:0] CESBD_MSG_RESET = 16'h0000;
    localparam logic [15:0] CESBD_FLAGS_RESET = 16'h0000;
    localparam logic CESBD_CFG_RESET = 1'b1;

    // one-cycle error events from the protocol engine
    typedef struct packed {
        logic dlc_mismatch;
        logic esi_seen;
        logic d_crc;
        logic d_stuff;
        logic d_form;
        logic d_bit1;
        logic d_bit0;
        logic bus_off_recovered;
        logic n_crc;
        logic n_stuff;
        logic n_form;
        logic n_ack;
        logic n_bit1;
        logic n_bit0;
        logic data_tx_err;
        logic data_rx_err;
        logic nom_tx_err;
        logic nom_rx_err;
        logic msg_ok;
    } cesbd_event_type;

    // fault confinement outputs
    typedef struct packed {
        logic bus_off_state;
        logic tx_error_passive;
        logic rx_error_passive;
        logic tx_warning;
        logic rx_warning;
        logic any_warning;
    } cesbd_state_type;

    // whole register state
    typedef struct packed {
        logic [7:0] data_phase_tx_err_count;
        logic [7:0] data_phase_rx_err_count;
        logic [7:0] nominal_tx_err_count;
        logic [7:0] nominal_rx_err_count;
        logic [15:0] flags;
        logic [15:0] error_free_message_count;
        logic config_mode;
        logic [31:0] prdata;
    } cesbd_regs_type;

endpackage

// File: hw/cesbd_top.sv
// error state flags, diagnostic counters and flags with an apb register port
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - bus-off when transmit count above 255
// - configuration mode reports bus-off set
// - transmit error passive above 127
// - receive error passive above 127
// - transmit warning between 96 and 127
// - receive warning between 96 and 127
// - combined warning is either warning
// - counts shown in error count register
// - data phase transmit and receive counters
// - nominal phase transmit and receive counters
// - length mismatch flag on oversize DLC
// - flag set on received ESI bit
// - data phase crc stuff form bit flags
// - bus-off event flag on recovery
// - nominal crc error flag
// - nominal stuff error flag
// - nominal form error flag
// - acknowledge error flag
// - recessive bit error flag
// - dominant bit error flag
// - 16-bit error free message counter
// - unimplemented bits read zero
module cesbd_top
    import cesbd_pkg::*;
(
    input wire logic pclk, // 200 MHz clock
    input wire logic presetn, // async reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error on unmapped address
    input wire logic [8:0] transmit_error_count_in, // engine tx count, 9 bits
    input wire logic [7:0] receive_error_count_in, // engine rx count
    input wire cesbd_event_type events, // one-cycle events from engine
    output cesbd_state_type err_state // fault confinement flags
);

    cesbd_regs_type r_q;
    cesbd_regs_type r_d;
    logic [8:0] tx_cnt;
    logic [7:0] tx_cnt_shown;
    logic [8:0] rx_cnt_wide;
    logic [15:0] flag_set;
    logic [15:0] flag_wr;
    logic [31:0] cnt_wr;
    logic [31:0] err_word;
    logic mapped;
    logic wr_en;
    logic rd_en;
    cesbd_state_type st;

    // confinement state from the counts
    always_comb begin
        tx_cnt = transmit_error_count_in;
        rx_cnt_wide = {1'b0, receive_error_count_in};
        tx_cnt_shown = (tx_cnt > CESBD_BUS_OFF_LIMIT) ? 8'hFF : tx_cnt[7:0];
        st.bus_off_state = (tx_cnt > CESBD_BUS_OFF_LIMIT) || r_q.config_mode;
        st.tx_error_passive = tx_cnt > CESBD_PASSIVE_LIMIT;
        st.rx_error_passive = rx_cnt_wide > CESBD_PASSIVE_LIMIT;
        st.tx_warning = (tx_cnt > CESBD_WARN_LOW) && (tx_cnt < CESBD_WARN_HIGH);
        st.rx_warning = (rx_cnt_wide > CESBD_WARN_LOW) && (rx_cnt_wide < CESBD_WARN_HIGH);
        st.any_warning = st.tx_warning || st.rx_warning;
    end

    assign err_state = st;

    // error count register image
    always_comb begin
        err_word = 32'h0000_0000;
        err_word[CESBD_POS_BUS_OFF] = st.bus_off_state;
        err_word[CESBD_POS_TX_PASSIVE] = st.tx_error_passive;
        err_word[CESBD_POS_RX_PASSIVE] = st.rx_error_passive;
        err_word[CESBD_POS_TX_WARN] = st.tx_warning;
        err_word[CESBD_POS_RX_WARN] = st.rx_warning;
        err_word[CESBD_POS_ANY_WARN] = st.any_warning;
        err_word[15:8] = tx_cnt_shown;
        err_word[7:0] = receive_error_count_in;
    end

    // event vector in flag register order
    always_comb begin
        flag_set = 16'h0000;
        flag_set[CESBD_POS_DLC_MM - 16] = events.dlc_mismatch;
        flag_set[CESBD_POS_ESI - 16] = events.esi_seen;
        flag_set[CESBD_POS_D_CRC - 16] = events.d_crc;
        flag_set[CESBD_POS_D_STUFF - 16] = events.d_stuff;
        flag_set[CESBD_POS_D_FORM - 16] = events.d_form;
        flag_set[CESBD_POS_D_BIT1 - 16] = events.d_bit1;
        flag_set[CESBD_POS_D_BIT0 - 16] = events.d_bit0;
        flag_set[CESBD_POS_BO_EVT - 16] = events.bus_off_recovered;
        flag_set[CESBD_POS_N_CRC - 16] = events.n_crc;
        flag_set[CESBD_POS_N_STUFF - 16] = events.n_stuff;
        flag_set[CESBD_POS_N_FORM - 16] = events.n_form;
        flag_set[CESBD_POS_N_ACK - 16] = events.n_ack;
        flag_set[CESBD_POS_N_BIT1 - 16] = events.n_bit1;
        flag_set[CESBD_POS_N_BIT0 - 16] = events.n_bit0;
    end

    // apb decode, zero wait states
    always_comb begin
        mapped = (paddr == CESBD_OFS_ERR_COUNT) || (paddr == CESBD_OFS_DIAG_CNT) ||
                 (paddr == CESBD_OFS_DIAG_FLAGS) || (paddr == CESBD_OFS_CTRL);
        wr_en = psel && penable && pwrite && mapped;
        rd_en = psel && !penable && !pwrite;
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = r_q.prdata;

    // per-byte strobes expanded over the write data
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_strb
            assign cnt_wr[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate
    assign flag_wr = cnt_wr[31:16] & CESBD_FLAG_MASK;

    // saturating increment
    function automatic logic [7:0] sat_inc8(input logic [7:0] v, input logic e);
        sat_inc8 = (e && v != 8'hFF) ? v + 8'h01 : v;
    endfunction

    // next state of all registers
    always_comb begin
        r_d = r_q;
        r_d.data_phase_tx_err_count =
            sat_inc8(r_q.data_phase_tx_err_count, events.data_tx_err);
        r_d.data_phase_rx_err_count =
            sat_inc8(r_q.data_phase_rx_err_count, events.data_rx_err);
        r_d.nominal_tx_err_count =
            sat_inc8(r_q.nominal_tx_err_count, events.nom_tx_err);
        r_d.nominal_rx_err_count =
            sat_inc8(r_q.nominal_rx_err_count, events.nom_rx_err);
        if (events.msg_ok && r_q.error_free_message_count != 16'hFFFF) begin
            r_d.error_free_message_count = r_q.error_free_message_count + 16'h0001;
        end
        // a software write to a counter overrides this cycle's increment
        if (wr_en && paddr == CESBD_OFS_DIAG_CNT) begin
            r_d.data_phase_tx_err_count = (pwdata[31:24] & cnt_wr[31:24]) |
                (r_q.data_phase_tx_err_count & ~cnt_wr[31:24]);
            r_d.data_phase_rx_err_count = (pwdata[23:16] & cnt_wr[23:16]) |
                (r_q.data_phase_rx_err_count & ~cnt_wr[23:16]);
            r_d.nominal_tx_err_count = (pwdata[15:8] & cnt_wr[15:8]) |
                (r_q.nominal_tx_err_count & ~cnt_wr[15:8]);
            r_d.nominal_rx_err_count = (pwdata[7:0] & cnt_wr[7:0]) |
                (r_q.nominal_rx_err_count & ~cnt_wr[7:0]);
        end
        r_d.flags = r_q.flags;
        if (wr_en && paddr == CESBD_OFS_DIAG_FLAGS) begin
            r_d.flags = (r_q.flags & ~flag_wr) | (pwdata[31:16] & flag_wr);
            r_d.error_free_message_count = (pwdata[15:0] & cnt_wr[15:0]) |
                (r_q.error_free_message_count & ~cnt_wr[15:0]);
        end
        r_d.flags = (r_d.flags | flag_set) & CESBD_FLAG_MASK;
        if (wr_en && paddr == CESBD_OFS_CTRL && pstrb[0]) begin
            r_d.config_mode = pwdata[0];
        end
        // read data latched in the setup cycle
        if (rd_en) begin
            case (paddr)
                CESBD_OFS_ERR_COUNT: r_d.prdata = err_word;
                CESBD_OFS_DIAG_CNT: r_d.prdata = {r_q.data_phase_tx_err_count,
                    r_q.data_phase_rx_err_count, r_q.nominal_tx_err_count,
                    r_q.nominal_rx_err_count};
                CESBD_OFS_DIAG_FLAGS: r_d.prdata = {r_q.flags,
                    r_q.error_free_message_count};
                CESBD_OFS_CTRL: r_d.prdata = {31'h0000_0000, r_q.config_mode};
                default: r_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q.data_phase_tx_err_count <= CESBD_CNT_RESET;
            r_q.data_phase_rx_err_count <= CESBD_CNT_RESET;
            r_q.nominal_tx_err_count <= CESBD_CNT_RESET;
            r_q.nominal_rx_err_count <= CESBD_CNT_RESET;
            r_q.flags <= CESBD_FLAGS_RESET;
            r_q.error_free_message_count <= CESBD_MSG_RESET;
            r_q.config_mode <= CESBD_CFG_RESET;
            r_q.prdata <= 32'h0000_0000;
        end else begin
            r_q <= r_d;
        end
    end

endmodule // cesbd_top

`default_nettype wire

// File: sim/cesbd_engine_model.sv
// protocol engine stand-in: error counts and one-cycle error events
`timescale 1ns/1ps
`default_nettype none
module cesbd_engine_model
    import cesbd_pkg::*;
(
    input wire logic pclk, // block clock
    output logic [8:0] tx_cnt_q, // transmit error count
    output logic [7:0] rx_cnt_q, // receive error count
    output cesbd_event_type ev_q // one-cycle events
);
    // quiet engine at time zero
    initial begin
        tx_cnt_q = 9'h000;
        rx_cnt_q = 8'h00;
        ev_q = '0;
    end
    // new counts, called right after a clock edge
    task automatic set_counts(input logic [8:0] t, input logic [7:0] r);
        tx_cnt_q <= t;
        rx_cnt_q <= r;
    endtask
    // one event bit high for exactly one cycle, then a quiet cycle
    task automatic pulse(input int idx);
        ev_q <= cesbd_event_type'(19'h00001 << idx);
        @(posedge pclk);
        ev_q <= '0;
        @(posedge pclk);
    endtask
endmodule // cesbd_engine_model
`default_nettype wire

// File: sim/cesbd_top_sva.sv
// assertions on the error state flags and register reads
`timescale 1ns/1ps
`default_nettype none
module cesbd_top_chk
    import cesbd_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    input wire logic [8:0] transmit_error_count_in, // tx count
    input wire logic [7:0] receive_error_count_in, // rx count
    input wire cesbd_state_type err_state // confinement flags
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // short aliases and the shown transmit count
    wire [8:0] tx_cnt = transmit_error_count_in;
    wire [7:0] rx_cnt = receive_error_count_in;
    wire [7:0] tx_shown = (tx_cnt > CESBD_BUS_OFF_LIMIT) ? 8'hFF : tx_cnt[7:0];
    wire rd = psel && penable && !pwrite;
    cesbd_state_type st;
    assign st = err_state;

    chk_bus_off_high: assert property (tx_cnt > CESBD_BUS_OFF_LIMIT |-> st.bus_off_state)
        else $error("bus off flag missing");
    chk_tx_passive: assert property (
        st.tx_error_passive == (tx_cnt > CESBD_PASSIVE_LIMIT))
        else $error("tx passive flag wrong");
    chk_rx_passive: assert property (st.rx_error_passive == (rx_cnt > 8'h7F))
        else $error("rx passive flag wrong");
    chk_tx_warn_band: assert property (
        st.tx_warning == (tx_cnt > 9'h05F && tx_cnt < 9'h080))
        else $error("tx warning flag wrong");
    chk_rx_warn_band: assert property (
        st.rx_warning == (rx_cnt > 8'h5F && rx_cnt < 8'h80))
        else $error("rx warning flag wrong");
    chk_any_warn: assert property (st.any_warning == (st.tx_warning || st.rx_warning))
        else $error("combined warning wrong");
    chk_status_read: assert property (rd && paddr == CESBD_OFS_ERR_COUNT |->
        prdata == {10'h000, $past(st), $past(tx_shown), $past(rx_cnt)})
        else $error("status read wrong");
    chk_flag_holes: assert property (rd && paddr == CESBD_OFS_DIAG_FLAGS |->
        !prdata[26] && !prdata[22])
        else $error("unused flag bit set");

    cover property (st.bus_off_state && tx_cnt > CESBD_BUS_OFF_LIMIT);
    cover property (pslverr);
    cover property (psel && penable && pwrite && paddr == CESBD_OFS_DIAG_FLAGS);
endmodule // cesbd_top_chk

bind cesbd_top cesbd_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .transmit_error_count_in(transmit_error_count_in),
    .receive_error_count_in(receive_error_count_in), .err_state(err_state));
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench: apb reads queued against a monitor, engine model drives events
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cesbd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, acc;
    logic [3:0] pstrb;
    logic [8:0] tx_cnt, t;
    logic [7:0] rx_cnt, r;
    cesbd_event_type ev;
    cesbd_state_type st;
    logic [32:0] exq[$];
    int fails, comparisons;
    int fp[14] = '{31, 30, 29, 28, 27, 25, 24, 23, 21, 20, 19, 18, 17, 16};
    int cnt[4] = '{3, 2, 1, 4};
    logic [8:0] bnd[8] = '{9'h000, 9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h1FF};

    cesbd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .transmit_error_count_in(tx_cnt),
        .receive_error_count_in(rx_cnt), .events(ev), .err_state(st));
    cesbd_engine_model i_eng (.pclk(pclk), .tx_cnt_q(tx_cnt), .rx_cnt_q(rx_cnt), .ev_q(ev));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // status word expected from the counts
    function automatic logic [31:0] exp_st(logic [8:0] c, logic [7:0] r, logic cfg);
        logic [5:0] s;
        s = {cfg || c > 255, c > 127, r > 127, c > 95 && c < 128, r > 95 && r < 128, 1'b0};
        s[0] = s[2] | s[1];
        return {10'h000, s, (c > 255) ? 8'hFF : c[7:0], r};
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s, logic [32:0] e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        if (!w) exq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            fails++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0, {1'b0, e});
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
        apb(1'b1, a, d, s, 33'h0_0000_0000);
    endtask
    // monitor: oldest expectation against each completed read
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            comparisons++;
            if (exq.size() == 0 || {pslverr, prdata} !== exq[0]) begin
                fails++;
                $display("wrong value at %0t: got %h expected %h", $time, {pslverr, prdata},
                    exq[0]);
            end
            if (exq.size() > 0) void'(exq.pop_front());
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
        fails = 0;
        comparisons = 0;
        acc = 32'h0000_0000;
        void'($urandom(31533));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CESBD_OFS_ERR_COUNT, exp_st(9'h000, 8'h00, 1'b1));
        rd(CESBD_OFS_DIAG_CNT, 32'h0000_0000);
        rd(CESBD_OFS_CTRL, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000, 4'h0, {1'b1, 32'h0000_0000});
        wr(CESBD_OFS_CTRL, 32'h0000_0000, 4'hF);
        wr(CESBD_OFS_ERR_COUNT, 32'hFFFF_FFFF, 4'hF);
        // count boundaries, then random counts
        for (int i = 0; i < 14; i++) begin
            t = (i < 8) ? bnd[i] : 9'($urandom_range(511, 0));
            r = (i < 8) ? t[7:0] : 8'($urandom);
            i_eng.set_counts(t, r);
            rd(CESBD_OFS_ERR_COUNT, exp_st(t, r, 1'b0));
        end
        // each error flag raised in turn and kept
        for (int i = 0; i < 14; i++) begin
            acc[fp[i]] = 1'b1;
            i_eng.pulse(18 - i);
            rd(CESBD_OFS_DIAG_FLAGS, acc);
        end
        wr(CESBD_OFS_DIAG_FLAGS, 32'h0000_0000, 4'hC);
        rd(CESBD_OFS_DIAG_FLAGS, 32'h0000_0000);
        wr(CESBD_OFS_DIAG_FLAGS, 32'hFFFF_0000, 4'hC);
        rd(CESBD_OFS_DIAG_FLAGS, 32'hFBBF_0000);
        wr(CESBD_OFS_DIAG_FLAGS, 32'h0000_0000, 4'hC);
        // phase counters, then saturation after a load
        for (int i = 0; i < 4; i++) repeat (cnt[i]) i_eng.pulse(4 - i);
        rd(CESBD_OFS_DIAG_CNT, 32'h0302_0104);
        wr(CESBD_OFS_DIAG_CNT, 32'hFEFE_FEFE, 4'hF);
        for (int i = 0; i < 8; i++) i_eng.pulse(4 - i % 4);
        rd(CESBD_OFS_DIAG_CNT, 32'hFFFF_FFFF);
        repeat (3) i_eng.pulse(0);
        rd(CESBD_OFS_DIAG_FLAGS, 32'h0000_0003);
        wr(CESBD_OFS_DIAG_FLAGS, 32'h0000_FFFE, 4'h3);
        repeat (2) i_eng.pulse(0);
        rd(CESBD_OFS_DIAG_FLAGS, 32'h0000_FFFF);
        wr(CESBD_OFS_CTRL, 32'h0000_0001, 4'hF);
        i_eng.set_counts(9'h000, 8'h00);
        rd(CESBD_OFS_ERR_COUNT, exp_st(9'h000, 8'h00, 1'b1));
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
